/* design/sbciwu_pkg.sv */
/*
 * Shared constants and carrier types of the interrupt and wake-up unit.
 * Assumes a single 250 MHz system clock and plain-port control bits.
 */
// Overview of operation
// - raise enabled sources only
// - event pulls primary, critical also priority
// - interrupt in sleep wakes into reset
// - wake-ups and interrupts are one
// - primary stays low after wake-up, priority only for critical
// - open-drain outputs, never driven high
// - primary low for any pending, delay-gated
// - only critical sources reach priority output
// - one pending bit per source
// - group summary of pending bits
// - write one clears, zero keeps
// - release outputs when all clear
// - clear releases primary, starts delay timer
// - during delay capture, primary stays high
// - status readable and clearable any time
// - reset output low stops timer
// - priority output ignores delay timer
// - wake sources regular, others diagnostic
// - sleep with no regular enabled resets
// - sleep request while pending goes reset
// - four sources have no enable
package sbciwu_pkg;
   localparam int unsigned NUM_SRC = 16;
   localparam int unsigned NUM_GRP = 5;
   // source map: bits 0..3 regular wake sources, rest diagnostic
   localparam logic [15:0] REGULAR_MASK  = 16'h000f;
   localparam logic [15:0] CRITICAL_MASK = 16'hf800;
   // watchdog_fail_irq bit 4, pn_frame_error_irq 5, power_on_irq 6,
   // overvoltage_shutdown_irq 11
   localparam logic [15:0] ALWAYS_EN_MASK = 16'h0870;
   localparam logic [15:0] GRP_SYS_MASK   = 16'h0070;
   localparam logic [15:0] GRP_SUP_MASK   = 16'hff80;
   localparam logic [15:0] GRP_TRX_MASK   = 16'h0003;
   localparam logic [15:0] GRP_BANK0_MASK = 16'h0004;
   localparam logic [15:0] GRP_BANK1_MASK = 16'h0008;
   localparam logic [15:0] STATUS_RST    = 16'h0000;
   localparam logic [2:0]  MODE_CODE_SLEEP = 3'h1;
   localparam int unsigned CLK_MHZ       = 250;
   localparam int unsigned IRQ_DELAY_US  = 100;
   localparam int unsigned IRQ_DELAY_CYC = IRQ_DELAY_US * CLK_MHZ;
   localparam int unsigned TMR_W         = 32;

   typedef enum logic [1:0] {
      SBCIWU_MODE_RUN   = 2'b00,
      SBCIWU_MODE_SLEEP = 2'b01,
      SBCIWU_MODE_RESET = 2'b10
   } sbciwu_mode_type;

   typedef struct packed {
      logic [NUM_SRC-1:0] status;
   } sbciwu_stat_type;

   typedef struct packed {
      logic          pri_oe;
      logic          prio_oe;
      logic          wake;
      logic          sys_reset;
   } sbciwu_out_type;
endpackage : sbciwu_pkg

/* design/sbciwu_sync.sv */
/*
 * Two-flop synchroniser bank for asynchronous event inputs.
 * Assumes inputs arrive from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module sbciwu_sync import sbciwu_pkg::*; (
   input  wire logic               sys_clk_i,
   input  wire logic               rst_i,
   input  wire logic               clk_en_i,
   input  wire logic [NUM_SRC-1:0] async_i,
   output logic      [NUM_SRC-1:0] sync_o
);
   typedef struct packed {
      logic [NUM_SRC-1:0] s1;
      logic [NUM_SRC-1:0] s2;
   } sbciwu_sync_type;
   sbciwu_sync_type st_q, st_d;

   // first stage read only by second stage
   always_comb begin
      st_d = st_q;
      if (clk_en_i) begin
         st_d.s1 = async_i;
         st_d.s2 = st_q.s1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.s2;
endmodule : sbciwu_sync
`default_nettype wire

/* design/sbciwu_delay.sv */
/*
 * Interrupt delay timer: runs after a status clear, gates primary line.
 * Assumes reset_out_n is already synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module sbciwu_delay import sbciwu_pkg::*; #(
   parameter int unsigned DELAY_CYC = IRQ_DELAY_CYC
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic clk_en_i,
   input  wire logic start_i,
   input  wire logic reset_out_n_i,
   output logic      running_o
);
   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic             run;
   } sbciwu_dly_type;
   sbciwu_dly_type st_q, st_d;

   // restart on every clear; stopped at once while reset output low
   always_comb begin
      st_d = st_q;
      if (clk_en_i) begin
         if (!reset_out_n_i) begin
            st_d.run = 1'b0;
            st_d.cnt = '0;
         end else if (start_i) begin
            st_d.run = 1'b1;
            st_d.cnt = TMR_W'(DELAY_CYC - 1);
         end else if (st_q.run) begin
            if (st_q.cnt == '0) begin
               st_d.run = 1'b0;
            end else begin
               st_d.cnt = st_q.cnt - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign running_o = st_q.run;
endmodule : sbciwu_delay
`default_nettype wire

/* design/sbciwu_top.sv */
/*
 * Interrupt and wake-up unit top: sticky pending bits, enables, group
 * summary, open-drain primary and priority lines, sleep guarding.
 * Assumes events are async levels/pulses, control bits are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module sbciwu_top import sbciwu_pkg::*; #(
   parameter int unsigned DELAY_CYC = IRQ_DELAY_CYC
) (
   input  wire logic               sys_clk_i,
   input  wire logic               rst_i,
   input  wire logic               clk_en_i,
   input  wire logic [NUM_SRC-1:0] event_i,
   input  wire logic [NUM_SRC-1:0] enable_i,
   input  wire logic [NUM_SRC-1:0] clear_i,
   input  wire logic               clear_stb_i,
   input  wire logic [2:0]         operating_mode_code_i,
   input  wire logic               mode_stb_i,
   input  wire logic               reset_out_n_i,
   input  wire logic               irq_out_primary_n_i,
   input  wire logic               irq_out_priority_n_i,
   output logic      [NUM_SRC-1:0] status_o,
   output logic      [NUM_GRP-1:0] group_o,
   output logic                    irq_out_primary_n_o,
   output logic                    irq_out_primary_n_oe_o,
   output logic                    irq_out_priority_n_o,
   output logic                    irq_out_priority_n_oe_o,
   output logic                    sleep_o,
   output logic                    wake_o,
   output logic                    sys_reset_o
);
   typedef struct packed {
      sbciwu_stat_type  stat;
      sbciwu_mode_type  mode;
      sbciwu_out_type   out;
      logic [NUM_GRP-1:0] grp;
      logic               clr;
   } sbciwu_top_type;
   sbciwu_top_type st_q, st_d;

   logic [NUM_SRC-1:0] ev_sync;
   logic [NUM_SRC-1:0] eff_en;
   logic [NUM_SRC-1:0] raise;
   logic [NUM_SRC-1:0] cleared;
   logic [NUM_SRC-1:0] nxt;
   logic               dly_run;
   logic               any_pend;

   sbciwu_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .clk_en_i  (clk_en_i),
      .async_i   (event_i),
      .sync_o    (ev_sync)
   );

   sbciwu_delay #(
      .DELAY_CYC (DELAY_CYC)
   ) u_delay (
      .sys_clk_i     (sys_clk_i),
      .rst_i         (rst_i),
      .clk_en_i      (clk_en_i),
      .start_i       (st_q.clr),
      .reset_out_n_i (reset_out_n_i),
      .running_o     (dly_run)
   );

   // always-enabled sources ignore their enable input
   assign eff_en = enable_i | ALWAYS_EN_MASK;
   assign raise  = ev_sync & eff_en;
   assign cleared = (clear_stb_i ? clear_i : '0) & st_q.stat.status;

   // per-bit sticky pending bit; the set wins over a same-cycle clear
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_bit
         assign nxt[gi] = raise[gi] | (st_q.stat.status[gi] & ~cleared[gi]);
      end
   endgenerate

   assign any_pend = |st_q.stat.status;

   // main next-state process
   always_comb begin
      st_d = st_q;
      if (clk_en_i) begin
         st_d.stat.status = nxt;
         st_d.clr = |cleared;
         st_d.grp[0] = |(nxt & GRP_SYS_MASK);
         st_d.grp[1] = |(nxt & GRP_SUP_MASK);
         st_d.grp[2] = |(nxt & GRP_TRX_MASK);
         st_d.grp[3] = |(nxt & GRP_BANK0_MASK);
         st_d.grp[4] = |(nxt & GRP_BANK1_MASK);
         st_d.out.wake = 1'b0;
         st_d.out.sys_reset = 1'b0;
         // primary: any pending, held off by a fresh clear, the gap cycle
         // before the timer starts, and the running timer
         st_d.out.pri_oe = (|nxt) & ~dly_run & ~(|cleared) & ~st_q.clr;
         // priority: critical only, timer plays no part
         st_d.out.prio_oe = |(nxt & CRITICAL_MASK);
         unique case (st_q.mode)
            SBCIWU_MODE_RUN: begin
               if (mode_stb_i && operating_mode_code_i == MODE_CODE_SLEEP) begin
                  if (~|(enable_i & REGULAR_MASK)) begin
                     st_d.out.sys_reset = 1'b1;
                     st_d.mode = SBCIWU_MODE_RESET;
                  end else if (any_pend || (|raise)) begin
                     st_d.mode = SBCIWU_MODE_RESET;
                  end else begin
                     st_d.mode = SBCIWU_MODE_SLEEP;
                  end
               end
            end
            SBCIWU_MODE_SLEEP: begin
               // any raised interrupt is a wake-up
               if (|raise) begin
                  st_d.out.wake = 1'b1;
                  st_d.mode = SBCIWU_MODE_RESET;
               end
            end
            SBCIWU_MODE_RESET: begin
               // leave as soon as the reset output reads high
               if (reset_out_n_i) begin
                  st_d.mode = SBCIWU_MODE_RUN;
               end
            end
            default: begin
               st_d.mode = SBCIWU_MODE_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= '{stat: '{status: STATUS_RST}, mode: SBCIWU_MODE_RUN,
                   out: '0, grp: '0, clr: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // open-drain: data always low, only the enable moves
   assign irq_out_primary_n_o     = 1'b0;
   assign irq_out_primary_n_oe_o  = st_q.out.pri_oe;
   assign irq_out_priority_n_o    = 1'b0;
   assign irq_out_priority_n_oe_o = st_q.out.prio_oe;
   assign status_o    = st_q.stat.status;
   assign group_o     = st_q.grp;
   assign sleep_o     = (st_q.mode == SBCIWU_MODE_SLEEP);
   assign wake_o      = st_q.out.wake;
   assign sys_reset_o = st_q.out.sys_reset;
endmodule : sbciwu_top
`default_nettype wire

/* sim/sbciwu_host.sv */
/* host side of the two interrupt lines: pull-ups and pad levels
   assumes pull-ups to the host supply on both lines */
`timescale 1ns/1ps
`default_nettype none
module sbciwu_host (
   input  wire logic pri_n_i,
   input  wire logic pri_oe_i,
   input  wire logic prio_n_i,
   input  wire logic prio_oe_i,
   output logic      pri_line_o,
   output logic      prio_line_o
);
   // released line floats up, so only a pull shows low
   assign pri_line_o  = pri_oe_i ? pri_n_i : 1'b1;
   assign prio_line_o = prio_oe_i ? prio_n_i : 1'b1;
endmodule : sbciwu_host
`default_nettype wire

/* sim/sbciwu_top_sva.sv */
/* port checker for sbciwu_top, bound below
   assumes DELAY_CYC of 8 */
`timescale 1ns/1ps
`default_nettype none
module sbciwu_top_sva import sbciwu_pkg::*; #(
   parameter int unsigned DELAY_CYC = 8
) (
   input wire logic               sys_clk_i,
   input wire logic               rst_i,
   input wire logic               clk_en_i,
   input wire logic [NUM_SRC-1:0] enable_i,
   input wire logic [NUM_SRC-1:0] clear_i,
   input wire logic               clear_stb_i,
   input wire logic [2:0]         operating_mode_code_i,
   input wire logic               mode_stb_i,
   input wire logic               reset_out_n_i,
   input wire logic [NUM_SRC-1:0] status_o,
   input wire logic               irq_out_primary_n_o,
   input wire logic               irq_out_primary_n_oe_o,
   input wire logic               irq_out_priority_n_o,
   input wire logic               irq_out_priority_n_oe_o,
   input wire logic               sleep_o,
   input wire logic               wake_o,
   input wire logic               sys_reset_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // request decodes shared by several properties
   logic clr_go, slp_go;
   assign clr_go = clear_stb_i && clk_en_i;
   assign slp_go = mode_stb_i && clk_en_i && operating_mode_code_i == MODE_CODE_SLEEP;
   property p_od; irq_out_primary_n_o == 1'b0 && irq_out_priority_n_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("line driven high");
   property p_prio; irq_out_priority_n_oe_o == |(status_o & CRITICAL_MASK); endproperty
   a_prio: assert property (p_prio) else $error("priority line off");
   property p_rel; status_o == 16'h0000 |-> !irq_out_primary_n_oe_o; endproperty
   a_rel: assert property (p_rel) else $error("primary held with none pending");
   // hold-off checked only while the reset output stays high
   property p_dly;
      disable iff (rst_i || !reset_out_n_i)
      clr_go && |(clear_i & status_o) |=> (!irq_out_primary_n_oe_o) [*8];
   endproperty
   a_dly: assert property (p_dly) else $error("primary back too soon");
   property p_keep; !clr_go |=> (status_o & $past(status_o)) == $past(status_o); endproperty
   a_keep: assert property (p_keep) else $error("pending bit lost");
   property p_w0;
      clr_go |=> (status_o & $past(status_o) & ~$past(clear_i))
                 == ($past(status_o) & ~$past(clear_i));
   endproperty
   a_w0: assert property (p_w0) else $error("zero write cleared a bit");
   property p_srst; slp_go && (enable_i & REGULAR_MASK) == 16'h0000 |=> sys_reset_o; endproperty
   a_srst: assert property (p_srst) else $error("no system reset");
   property p_spend; slp_go && status_o != 16'h0000 |=> !sleep_o; endproperty
   a_spend: assert property (p_spend) else $error("slept while pending");
   property p_wake; wake_o |-> $past(sleep_o) && !sleep_o; endproperty
   a_wake: assert property (p_wake) else $error("wake outside sleep");
endmodule : sbciwu_top_sva
bind sbciwu_top sbciwu_top_sva #(.DELAY_CYC(DELAY_CYC)) u_sva (.*);
`default_nettype wire

/* sim/test_sbc_interrupt_wakeup_unit.sv */
/* self-checking bench for sbciwu_top with host model
   assumes DELAY_CYC of 8; reset output and clock enable driven here */
`timescale 1ns/1ps
`default_nettype none
module test_sbc_interrupt_wakeup_unit import sbciwu_pkg::*; ;
   typedef struct packed {logic [15:0] ev, en, st; logic [4:0] grp;} sbciwu_row_type;
   logic        sys_clk_i = 1'b0, rst_i = 1'b1, clear_stb_i = 1'b0, mode_stb_i = 1'b0;
   logic [15:0] event_i = 16'h0000, enable_i = 16'h0000, clear_i = 16'h0000, status_o;
   logic [2:0]  operating_mode_code_i = 3'h0;
   logic        clk_en = 1'b1, rst_out_n = 1'b1;
   logic [4:0]  group_o;
   logic        pri_n, pri_oe, prio_n, prio_oe, sleep_o, wake_o, sys_reset_o, pri_ln, prio_ln;
   int          errors = 0, tests_run = 0;
   // one source per row: event, enable, pending, group
   sbciwu_row_type rows [6] = '{'{16'h0001, 16'h0001, 16'h0001, 5'h04},
      '{16'h0008, 16'h0008, 16'h0008, 5'h10}, '{16'h0010, 16'h0000, 16'h0010, 5'h01},
      '{16'h0800, 16'h0000, 16'h0800, 5'h02}, '{16'h1000, 16'h0000, 16'h0000, 5'h00},
      '{16'h0080, 16'h0080, 16'h0080, 5'h02}};
   sbciwu_top #(.DELAY_CYC(8)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
      .event_i(event_i), .enable_i(enable_i), .clear_i(clear_i), .clear_stb_i(clear_stb_i),
      .operating_mode_code_i(operating_mode_code_i), .mode_stb_i(mode_stb_i),
      .reset_out_n_i(rst_out_n), .irq_out_primary_n_i(pri_ln), .irq_out_priority_n_i(prio_ln),
      .status_o(status_o), .group_o(group_o), .irq_out_primary_n_o(pri_n),
      .irq_out_primary_n_oe_o(pri_oe), .irq_out_priority_n_o(prio_n),
      .irq_out_priority_n_oe_o(prio_oe), .sleep_o(sleep_o), .wake_o(wake_o),
      .sys_reset_o(sys_reset_o));
   sbciwu_host host (.pri_n_i(pri_n), .pri_oe_i(pri_oe), .prio_n_i(prio_n),
      .prio_oe_i(prio_oe), .pri_line_o(pri_ln), .prio_line_o(prio_ln));
   // 250 MHz
   always #2 sys_clk_i = ~sys_clk_i;
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // strobes last one cycle; callers tick before the next strobe
   task automatic clr(input logic [15:0] m);
      clear_i = m;
      clear_stb_i = 1'b1;
      tick(1);
      clear_stb_i = 1'b0;
   endtask : clr
   task automatic slp;
      operating_mode_code_i = MODE_CODE_SLEEP;
      mode_stb_i = 1'b1;
      tick(1);
      mode_stb_i = 1'b0;
   endtask : slp
   task automatic stop_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test
   // watchdog: whole run is under two hundred cycles
   initial begin
      #8000;
      errors++;
      stop_test();
   end
   // main sequence
   initial begin
      int n;
      tick(20);
      rst_i = 1'b0;
      chk(status_o, 16'h0000);
      chk(16'(pri_ln), 16'h0001);
      for (int i = 0; i < 6; i++) begin
         enable_i = rows[i].en;
         // one-cycle pulse, then wait until the synchroniser is quiet
         event_i = rows[i].ev;
         tick(1);
         event_i = 16'h0000;
         tick(4);
         chk(status_o, rows[i].st);
         chk(16'(group_o), 16'(rows[i].grp));
         chk(16'(prio_ln), 16'(~|(rows[i].st & CRITICAL_MASK)));
         chk(16'(pri_ln), 16'(~|rows[i].st));
         clr(rows[i].st);
         chk(status_o, 16'h0000);
         chk(16'(pri_ln), 16'h0001);
         tick(12);
      end
      // partial clear, zero write, then a critical raise under the hold-off
      enable_i = 16'h1003;
      event_i = 16'h0003;
      tick(1);
      event_i = 16'h0000;
      tick(4);
      clr(16'h0002);
      tick(1);
      clr(16'h0000);
      chk(status_o, 16'h0001);
      event_i = 16'h1000;
      tick(4);
      chk(16'(prio_ln), 16'h0000);
      chk(16'(pri_ln), 16'h0001);
      event_i = 16'h0000;
      tick(6);
      chk(16'(pri_ln), 16'h0000);
      chk(status_o, 16'h1001);
      // reset output low mid hold-off: timer stops, primary returns early
      clr(16'h0001);
      chk(16'(pri_ln), 16'h0001);
      tick(1);
      chk(16'(pri_ln), 16'h0001);
      tick(1);
      rst_out_n = 1'b0;
      tick(3);
      chk(16'(pri_ln), 16'h0000);
      rst_out_n = 1'b1;
      clr(16'h1000);
      chk(16'(prio_ln), 16'h0001);
      // clock enable low freezes the synchroniser and pending bits
      clk_en = 1'b0;
      event_i = 16'h0001;
      tick(5);
      chk(status_o, 16'h0000);
      clk_en = 1'b1;
      tick(4);
      event_i = 16'h0000;
      chk(status_o, 16'h0001);
      tick(3);
      clr(16'h0001);
      tick(12);
      // sleep guards and wake-up
      enable_i = 16'h0000;
      slp();
      chk(16'(sys_reset_o), 16'h0001);
      tick(2);
      enable_i = 16'h0001;
      slp();
      chk(16'(sleep_o), 16'h0001);
      event_i = 16'h0001;
      for (n = 0; n < 10 && wake_o !== 1'b1; n++) tick(1);
      chk(16'(wake_o), 16'h0001);
      tick(1);
      event_i = 16'h0000;
      chk(16'(sleep_o), 16'h0000);
      chk(16'(pri_ln), 16'h0000);
      slp();
      chk(16'(sleep_o), 16'h0000);
      stop_test();
   end
endmodule : test_sbc_interrupt_wakeup_unit
`default_nettype wire
